// ==== pswin_pkg.sv ====
// Constants and types for the program space read window
package pswin_pkg;
    localparam int EA_W = 16;
    localparam int EA_LOW_W = 15;
    localparam int PROG_ADDR_W = 24;
    localparam int EDS_ADDR_W = 25;
    localparam int RD_PAGE_W = 10;
    localparam int TBL_PAGE_W = 8;
    localparam int WR_PAGE_W = 9;
    localparam int REG_ADDR_W = 2;
    localparam int COST_W = 3;

    localparam logic [REG_ADDR_W-1:0] REG_TABLE_PAGE = 2'h0;
    localparam logic [REG_ADDR_W-1:0] REG_READ_PAGE = 2'h1;
    localparam logic [REG_ADDR_W-1:0] REG_WRITE_PAGE = 2'h2;
    localparam logic [REG_ADDR_W-1:0] REG_RESET_CTL = 2'h3;

    localparam logic [TBL_PAGE_W-1:0] TABLE_PAGE_RESET = 8'h00;
    localparam logic [RD_PAGE_W-1:0] READ_PAGE_RESET = 10'h001;
    localparam logic [WR_PAGE_W-1:0] WRITE_PAGE_RESET = 9'h001;
    localparam logic REGULATOR_SLEEP_RESET = 1'b0;
    localparam int REGULATOR_SLEEP_BIT = 11;

    localparam logic [1:0] PAGE_KIND_LSW = 2'h2;
    localparam logic [1:0] PAGE_KIND_MSB = 2'h3;
    localparam logic [RD_PAGE_W-1:0] PAGE_ZERO = 10'h000;

    // Instruction cycles, one clock each
    localparam logic [COST_W-1:0] COST_DATA = 3'h1;
    localparam logic [COST_W-1:0] COST_WINDOW = 3'h5;
    localparam logic [COST_W-1:0] COST_PIPELINED = 3'h1;
    localparam logic [COST_W-1:0] COST_LAST = 3'h6;
    localparam logic [COST_W-1:0] COST_TABLE = 3'h5;

    typedef enum logic [2:0] {
        SRC_DATA,
        SRC_EDS,
        SRC_LSW,
        SRC_MSB,
        SRC_TBL_LO,
        SRC_TBL_HI,
        SRC_TRAP
    } src_t;

    typedef enum logic {
        ST_IDLE,
        ST_BUSY
    } state_t;
endpackage : pswin_pkg

// ==== program_space_read_window.sv ====
// Paged program space read window with page registers and read timing
`timescale 1ns/100ps
module program_space_read_window
    import pswin_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [REG_ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    input wire logic cpuRead,
    input wire logic [EA_W-1:0] cpuAddr,
    input wire logic cpuByte,
    input wire logic cpuTable,
    input wire logic cpuTableHigh,
    input wire logic rptActive,
    input wire logic rptPostTwo,
    input wire logic rptFirst,
    input wire logic rptLast,
    input wire logic rptIntExit,
    input wire logic rptIntResume,
    output logic cpuReady,
    output logic cpuDone,
    output logic [15:0] cpuRdData,
    output logic addrErrTrap,
    output logic [WR_PAGE_W-1:0] writePage,
    output logic dataRead,
    output logic [EA_W-1:0] dataAddr,
    output logic edsRead,
    output logic [EDS_ADDR_W-1:0] edsAddr,
    input wire logic [15:0] dataRdData,
    output logic progRead,
    output logic [PROG_ADDR_W-1:0] progAddr,
    input wire logic [PROG_ADDR_W-1:0] progRdData,
    input wire logic sleepMode,
    output logic flashRegStandby
);

    // Source of a read, from table flag, address and read page
    function automatic src_t routeRead(
        input logic isTable,
        input logic tableHigh,
        input logic [EA_W-1:0] ea,
        input logic [RD_PAGE_W-1:0] page
    );
        src_t r;
        if (isTable) begin
            r = tableHigh ? SRC_TBL_HI : SRC_TBL_LO;
        end else if (!ea[EA_W-1]) begin
            r = SRC_DATA;
        end else if (page == PAGE_ZERO) begin
            r = SRC_TRAP;
        end else if (page[RD_PAGE_W-1 -: 2] == PAGE_KIND_MSB) begin
            r = SRC_MSB;
        end else if (page[RD_PAGE_W-1 -: 2] == PAGE_KIND_LSW) begin
            r = SRC_LSW;
        end else begin
            r = SRC_EDS;
        end
        return r;
    endfunction : routeRead

    // Instruction cycles that a read occupies
    function automatic logic [COST_W-1:0] readCost(
        input src_t s,
        input logic inRepeat,
        input logic postTwo,
        input logic first,
        input logic intExit,
        input logic intResume,
        input logic last
    );
        logic [COST_W-1:0] c;
        c = COST_DATA;
        case (s)
            SRC_LSW, SRC_MSB: begin
                if (inRepeat && postTwo) begin
                    if (last) begin
                        c = COST_LAST;
                    end else if (first || intExit || intResume) begin
                        c = COST_WINDOW;
                    end else begin
                        c = COST_PIPELINED;
                    end
                end else begin
                    c = COST_WINDOW;
                end
            end
            SRC_TBL_LO, SRC_TBL_HI: begin
                c = COST_TABLE;
            end
            default: begin
                c = COST_DATA;
            end
        endcase
        return c;
    endfunction : readCost

    // Word mode ignores bit 0; byte mode returns the chosen byte low
    function automatic logic [15:0] pickBytes(
        input logic [15:0] word,
        input logic byteMode,
        input logic sel
    );
        logic [15:0] r;
        r = word;
        if (byteMode) begin
            r = {8'h00, sel ? word[15:8] : word[7:0]};
        end
        return r;
    endfunction : pickBytes

    logic [TBL_PAGE_W-1:0] tablePage;
    logic [RD_PAGE_W-1:0] readPage;
    logic regulatorSleep;
    logic [TBL_PAGE_W-1:0] next_tablePage;
    logic [RD_PAGE_W-1:0] next_readPage;
    logic [WR_PAGE_W-1:0] next_writePage;
    logic next_regulatorSleep;
    logic [15:0] next_regRdData;
    logic next_flashRegStandby;

    state_t state;
    state_t next_state;
    logic [COST_W-1:0] count;
    logic [COST_W-1:0] next_count;
    src_t src;
    src_t next_src;
    src_t reqSrc;
    logic byteMode;
    logic next_byteMode;
    logic byteSel;
    logic next_byteSel;
    logic next_cpuReady;
    logic next_cpuDone;
    logic [15:0] next_cpuRdData;
    logic next_addrErrTrap;
    logic next_dataRead;
    logic [EA_W-1:0] next_dataAddr;
    logic next_edsRead;
    logic [EDS_ADDR_W-1:0] next_edsAddr;
    logic next_progRead;
    logic [PROG_ADDR_W-1:0] next_progAddr;
    logic [15:0] rawWord;

    // Register file
    always_comb begin
        next_tablePage = tablePage;
        next_readPage = readPage;
        next_writePage = writePage;
        next_regulatorSleep = regulatorSleep;
        if (regWrite) begin
            case (regAddr)
                REG_TABLE_PAGE: next_tablePage = regWrData[TBL_PAGE_W-1:0];
                REG_READ_PAGE: next_readPage = regWrData[RD_PAGE_W-1:0];
                REG_WRITE_PAGE: next_writePage = regWrData[WR_PAGE_W-1:0];
                REG_RESET_CTL: next_regulatorSleep = regWrData[REGULATOR_SLEEP_BIT];
                default: next_tablePage = tablePage;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tablePage <= TABLE_PAGE_RESET;
            readPage <= READ_PAGE_RESET;
            writePage <= WRITE_PAGE_RESET;
            regulatorSleep <= REGULATOR_SLEEP_RESET;
        end else begin
            tablePage <= next_tablePage;
            readPage <= next_readPage;
            writePage <= next_writePage;
            regulatorSleep <= next_regulatorSleep;
        end
    end

    // Register read data stands one cycle only, zero otherwise
    always_comb begin
        next_regRdData = 16'h0000;
        if (regRead) begin
            case (regAddr)
                REG_TABLE_PAGE: next_regRdData = {8'h00, tablePage};
                REG_READ_PAGE: next_regRdData = {6'h00, readPage};
                REG_WRITE_PAGE: next_regRdData = {7'h00, writePage};
                REG_RESET_CTL: begin
                    next_regRdData[REGULATOR_SLEEP_BIT] = regulatorSleep;
                end
                default: next_regRdData = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData <= 16'h0000;
        end else begin
            regRdData <= next_regRdData;
        end
    end

    // Flash regulator standby while asleep, only when regulatorSleep is clear
    always_comb begin
        // Regulator state follows sleep directly, no settling modelled
        next_flashRegStandby = sleepMode && !regulatorSleep;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flashRegStandby <= 1'b0;
        end else begin
            flashRegStandby <= next_flashRegStandby;
        end
    end

    // Read engine; the page is captured at acceptance so a page write
    // during a long read does not disturb it
    always_comb begin
        reqSrc = routeRead(cpuTable, cpuTableHigh, cpuAddr, readPage);
        next_state = state;
        next_count = count;
        next_src = src;
        next_byteMode = byteMode;
        next_byteSel = byteSel;
        if (state == ST_BUSY) begin
            if (count == COST_DATA) begin
                next_state = ST_IDLE;
            end else begin
                next_count = count - COST_DATA;
            end
        end
        if (cpuRead && cpuReady) begin
            next_state = ST_BUSY;
            next_src = reqSrc;
            next_byteMode = cpuByte;
            next_byteSel = cpuAddr[0];
            next_count = readCost(reqSrc, rptActive, rptPostTwo, rptFirst,
                rptIntExit, rptIntResume, rptLast);
        end
        // Ready rises a cycle early so a following read loses no cycle
        next_cpuReady = (next_state == ST_IDLE) || (next_count == COST_DATA);
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            count <= COST_DATA;
            src <= SRC_DATA;
            byteMode <= 1'b0;
            byteSel <= 1'b0;
            cpuReady <= 1'b1;
        end else begin
            state <= next_state;
            count <= next_count;
            src <= next_src;
            byteMode <= next_byteMode;
            byteSel <= next_byteSel;
            cpuReady <= next_cpuReady;
        end
    end

    // Completion on the last busy cycle; the memory word is taken then,
    // when its address has been stable for the whole read
    always_comb begin
        next_cpuDone = 1'b0;
        next_addrErrTrap = 1'b0;
        next_cpuRdData = cpuRdData;
        case (src)
            SRC_LSW, SRC_TBL_LO: rawWord = progRdData[15:0];
            SRC_MSB: rawWord = {8'h00, progRdData[23:16]};
            // Phantom byte of the upper word always reads zero
            SRC_TBL_HI: rawWord = {8'h00, progRdData[23:16]};
            SRC_TRAP: rawWord = 16'h0000;
            default: rawWord = dataRdData;
        endcase
        if (state == ST_BUSY && count == COST_DATA) begin
            next_cpuDone = 1'b1;
            next_addrErrTrap = (src == SRC_TRAP);
            next_cpuRdData = pickBytes(rawWord, byteMode, byteSel);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cpuDone <= 1'b0;
            cpuRdData <= 16'h0000;
            addrErrTrap <= 1'b0;
        end else begin
            cpuDone <= next_cpuDone;
            cpuRdData <= next_cpuRdData;
            addrErrTrap <= next_addrErrTrap;
        end
    end

    // Memory strobes and addresses; addresses hold after the strobe
    // because both memories answer asynchronously from them
    always_comb begin
        next_dataRead = 1'b0;
        next_edsRead = 1'b0;
        next_progRead = 1'b0;
        next_dataAddr = dataAddr;
        next_edsAddr = edsAddr;
        next_progAddr = progAddr;
        if (cpuRead && cpuReady) begin
            case (reqSrc)
                SRC_DATA: begin
                    next_dataRead = 1'b1;
                    next_dataAddr = cpuAddr;
                end
                SRC_EDS: begin
                    // Write page never feeds this path
                    next_edsRead = 1'b1;
                    next_edsAddr = {readPage, cpuAddr[EA_LOW_W-1:0]};
                end
                SRC_LSW, SRC_MSB: begin
                    next_progRead = 1'b1;
                    next_progAddr = {1'b0, readPage[7:0],
                        cpuAddr[EA_LOW_W-1:0]};
                end
                SRC_TBL_LO, SRC_TBL_HI: begin
                    next_progRead = 1'b1;
                    next_progAddr = {tablePage, cpuAddr};
                end
                default: begin
                    next_progRead = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dataRead <= 1'b0;
            dataAddr <= 16'h0000;
            edsRead <= 1'b0;
            edsAddr <= 25'h0000000;
            progRead <= 1'b0;
            progAddr <= 24'h000000;
        end else begin
            dataRead <= next_dataRead;
            dataAddr <= next_dataAddr;
            edsRead <= next_edsRead;
            edsAddr <= next_edsAddr;
            progRead <= next_progRead;
            progAddr <= next_progAddr;
        end
    end
endmodule : program_space_read_window

// ==== pswin_checker_asserts.sv ====
// Checker for the program space read window
`timescale 1ns/100ps
module pswin_checker
    import pswin_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [REG_ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdData,
    input wire logic cpuRead,
    input wire logic [EA_W-1:0] cpuAddr,
    input wire logic cpuTable,
    input wire logic rptActive,
    input wire logic rptPostTwo,
    input wire logic rptFirst,
    input wire logic rptLast,
    input wire logic rptIntExit,
    input wire logic rptIntResume,
    input wire logic cpuReady,
    input wire logic cpuDone,
    input wire logic [15:0] cpuRdData,
    input wire logic addrErrTrap,
    input wire logic dataRead,
    input wire logic [EA_W-1:0] dataAddr,
    input wire logic progRead,
    input wire logic [PROG_ADDR_W-1:0] progAddr,
    input wire logic sleepMode,
    input wire logic flashRegStandby
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic sleepKeep;
    logic next_sleepKeep;
    logic take;
    logic spin;
    assign take = cpuRead && cpuReady && !cpuTable;
    assign spin = rptActive && rptPostTwo && !rptFirst && !rptIntExit && !rptIntResume;
    // Shadow of the regulator control bit, so the output can be judged against writes
    always_comb begin
        next_sleepKeep = sleepKeep;
        if (regWrite && regAddr == REG_RESET_CTL) begin
            next_sleepKeep = regWrData[REGULATOR_SLEEP_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            sleepKeep <= REGULATOR_SLEEP_RESET;
        end else begin
            sleepKeep <= next_sleepKeep;
        end
    end
    sequence s_winPlain; take && cpuAddr[15] && !rptActive ##1 progRead; endsequence
    sequence s_winLast; take && cpuAddr[15] && rptActive && rptPostTwo && rptLast ##1 progRead;
    endsequence
    sequence s_winFast; take && cpuAddr[15] && spin && !rptLast ##1 progRead; endsequence
    sequence s_winSlow; take && cpuAddr[15] && rptActive && !rptPostTwo ##1 progRead;
    endsequence
    sequence s_winEntry;
        take && cpuAddr[15] && rptActive && rptPostTwo && !rptLast
            && (rptFirst || rptIntExit || rptIntResume) ##1 progRead;
    endsequence
    sequence s_doneSix; !cpuDone [*5] ##1 cpuDone; endsequence
    property p_dataPath;
        take && !cpuAddr[15] |=> dataRead && !progRead && dataAddr == $past(cpuAddr);
    endproperty
    a_dataPath: assert property (p_dataPath) else $error("data read misrouted");
    property p_progAddr;
        take && cpuAddr[15] ##1 progRead
            |-> !progAddr[23] && progAddr[14:0] == $past(cpuAddr[14:0]);
    endproperty
    a_progAddr: assert property (p_progAddr) else $error("window address wrong");
    property p_winCost; s_winPlain |-> s_doneSix; endproperty
    a_winCost: assert property (p_winCost) else $error("window read cost wrong");
    property p_readyGap; s_winPlain |-> !cpuReady [*4] ##1 cpuReady; endproperty
    a_readyGap: assert property (p_readyGap) else $error("ready not back in time");
    property p_rptSlow; s_winSlow |-> s_doneSix; endproperty
    a_rptSlow: assert property (p_rptSlow) else $error("plain repeat cost wrong");
    property p_rptEntry; s_winEntry |-> s_doneSix; endproperty
    a_rptEntry: assert property (p_rptEntry) else $error("loop entry cost wrong");
    property p_tableCost; cpuRead && cpuReady && cpuTable |=> s_doneSix; endproperty
    a_tableCost: assert property (p_tableCost) else $error("table read cost wrong");
    property p_lastCost; s_winLast |-> !cpuDone [*6] ##1 cpuDone; endproperty
    a_lastCost: assert property (p_lastCost) else $error("last iteration cost wrong");
    property p_fastCost; s_winFast |=> cpuDone; endproperty
    a_fastCost: assert property (p_fastCost) else $error("loop iteration not fast");
    property p_trap; addrErrTrap |-> cpuDone && cpuRdData == 16'h0000; endproperty
    a_trap: assert property (p_trap) else $error("trap without zero data");
    property p_regIdle; !$past(regRead) |-> regRdData == 16'h0000; endproperty
    a_regIdle: assert property (p_regIdle) else $error("read data outside its cycle");
    property p_standby; !$past(rst) |-> flashRegStandby == $past(sleepMode && !sleepKeep);
    endproperty
    a_standby: assert property (p_standby) else $error("regulator standby wrong");
endmodule : pswin_checker

bind program_space_read_window pswin_checker u_chk (.*);

// ==== pswin_mem_model.sv ====
// Behavioural data memory and program flash facing the read window
`timescale 1ns/100ps
module pswin_mem_model
    import pswin_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic dataRead,
    input wire logic [EA_W-1:0] dataAddr,
    input wire logic edsRead,
    input wire logic [EDS_ADDR_W-1:0] edsAddr,
    input wire logic [PROG_ADDR_W-1:0] progAddr,
    output logic [15:0] dataRdData,
    output logic [PROG_ADDR_W-1:0] progRdData
);
    logic edsSel;
    // Shared read bus follows the most recent strobe, even within its own cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            edsSel <= 1'b0;
        end else if (edsRead || dataRead) begin
            edsSel <= edsRead;
        end
    end
    // Page bits fold into the data so a wrong page shows up as wrong data
    assign dataRdData = (edsRead || (edsSel && !dataRead))
        ? edsAddr[15:0] ^ {6'h00, edsAddr[24:15]} ^ 16'ha5a5 : dataAddr ^ 16'h5a5a;
    assign progRdData = {progAddr[7:0] ^ progAddr[22:15] ^ 8'h3c, progAddr[15:0]};
endmodule : pswin_mem_model

// ==== tb.sv ====
// Self-checking bench for the program space read window
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb;
    import pswin_pkg::*;
    logic clk, rst, regWrite, regRead, cpuRead, cpuByte, cpuTable, cpuTableHigh, sleepMode;
    logic rptActive, rptPostTwo, rptFirst, rptLast, rptIntExit, rptIntResume;
    logic cpuReady, cpuDone, addrErrTrap, dataRead, edsRead, progRead, flashRegStandby;
    logic [1:0] regAddr;
    logic [15:0] regWrData, regRdData, cpuAddr, cpuRdData, dataAddr, dataRdData;
    logic [8:0] writePage;
    logic [24:0] edsAddr;
    logic [23:0] progAddr, progRdData, w;
    int error_cnt = 0;
    int n_checks = 0;
    program_space_read_window dut (.*);
    pswin_mem_model model (.*);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [23:0] flash(input logic [23:0] a);
        return {a[7:0] ^ a[22:15] ^ 8'h3c, a[15:0]};
    endfunction : flash
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    task automatic regWr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : regWr
    task automatic regChk(input logic [1:0] a, input logic [15:0] e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 `CHK(regRdData, e)
    endtask : regChk
    // md is trap, byte, table, table high; rp is active, post two, first, last, exit, resume
    task automatic cpuChk(input logic [15:0] ea, input logic [3:0] md, input logic [5:0] rp,
            input logic [15:0] e, input int en);
        int n;
        @(posedge clk);
        cpuRead <= 1'b1;
        cpuAddr <= ea;
        {cpuByte, cpuTable, cpuTableHigh} <= md[2:0];
        {rptActive, rptPostTwo, rptFirst, rptLast, rptIntExit, rptIntResume} <= rp;
        @(posedge clk);
        cpuRead <= 1'b0;
        n = 1;
        #1;
        while (cpuDone !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        `CHK(cpuRdData, e)
        `CHK(n, en)
        `CHK(addrErrTrap, md[3])
    endtask : cpuChk
    task automatic test_regs();
        logic [15:0] rv[4] = '{16'h0000, 16'h0001, 16'h0001, 16'h0000};
        logic [15:0] mv[4] = '{16'h00ff, 16'h03ff, 16'h01ff, 16'h0800};
        for (int i = 0; i < 4; i++) regChk(2'(i), rv[i]);
        for (int i = 0; i < 4; i++) regWr(2'(i), 16'hffff);
        for (int i = 0; i < 4; i++) regChk(2'(i), mv[i]);
        regWr(REG_READ_PAGE, 16'h02a5);
        `CHK(writePage, 9'h1ff)
        regChk(REG_READ_PAGE, 16'h02a5);
        $display("test regs done");
    endtask : test_regs
    task automatic test_paths();
        w = flash({1'b0, 8'ha5, 15'h0004});
        cpuChk(16'h8004, 4'h0, 6'h00, w[15:0], 6);
        cpuChk(16'h8004, 4'h4, 6'h00, {8'h00, w[7:0]}, 6);
        w = flash({1'b0, 8'ha5, 15'h0005});
        cpuChk(16'h8005, 4'h4, 6'h00, {8'h00, w[15:8]}, 6);
        cpuChk(16'h1234, 4'h0, 6'h00, 16'h1234 ^ 16'h5a5a, 2);
        regWr(REG_READ_PAGE, 16'h03a5);
        cpuChk(16'h8005, 4'h0, 6'h00, {8'h00, w[23:16]}, 6);
        regWr(REG_READ_PAGE, 16'h0001);
        cpuChk(16'hc000, 4'h0, 6'h00, 16'hc000 ^ 16'h0001 ^ 16'ha5a5, 2);
        regWr(REG_READ_PAGE, 16'h0000);
        cpuChk(16'h8000, 4'h8, 6'h00, 16'h0000, 2);
        $display("test paths done");
    endtask : test_paths
    task automatic test_loops();
        logic [5:0] rk[7] = '{6'h38, 6'h30, 6'h32, 6'h31, 6'h30, 6'h34, 6'h20};
        int rn[7] = '{6, 2, 6, 6, 2, 7, 6};
        regWr(REG_READ_PAGE, 16'h0200);
        w = flash(24'h000002);
        for (int i = 0; i < 7; i++) begin
            cpuChk(16'h8002, 4'h0, rk[i], w[15:0], rn[i]);
        end
        regWr(REG_TABLE_PAGE, 16'h0012);
        w = flash(24'h120006);
        cpuChk(16'h0006, 4'h2, 6'h30, w[15:0], 6);
        cpuChk(16'h0006, 4'h3, 6'h00, {8'h00, w[23:16]}, 6);
        $display("test loops done");
    endtask : test_loops
    task automatic test_sleep();
        regWr(REG_RESET_CTL, 16'h0000);
        sleepMode <= 1'b1;
        repeat (2) @(posedge clk);
        #1 `CHK(flashRegStandby, 1'b1)
        regWr(REG_RESET_CTL, 16'h0800);
        repeat (2) @(posedge clk);
        #1 `CHK(flashRegStandby, 1'b0)
        sleepMode <= 1'b0;
        $display("test sleep done");
    endtask : test_sleep
    initial begin
        {rst, regWrite, regRead, cpuRead, cpuByte, cpuTable, cpuTableHigh, sleepMode} = 8'h80;
        {rptActive, rptPostTwo, rptFirst, rptLast, rptIntExit, rptIntResume} = 6'h00;
        {regAddr, regWrData, cpuAddr} = 34'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        test_regs();
        test_paths();
        test_loops();
        test_sleep();
        summarize();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
endmodule : tb
